//--- design/adta_pkg.sv
/*
 * Shared constants for the adaptive dead time adjust block: register
 * offsets, field positions, reset values and timing figures.
 * Assumes a 200 MHz controller clock and edge times counted in clock cycles.
 */
package adta_pkg;

    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned EDGE_W       = 16;
    localparam int unsigned SENSE_W      = 12;
    localparam int unsigned CODE_W       = 3;

    // Register offsets.
    localparam logic [ADDR_W-1:0] THRESH_OFFSET  = 8'h68;
    localparam logic [ADDR_W-1:0] EDGES12_OFFSET = 8'h69;

    // Reset values.
    localparam logic [DATA_W-1:0] THRESH_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] EDGES12_RESET  = 8'h00;

    // Field positions.
    localparam int unsigned THRESH_LSB     = 0;
    localparam int unsigned FIRST_POL_BIT  = 7;
    localparam int unsigned FIRST_MAG_LSB  = 4;
    localparam int unsigned SECOND_POL_BIT = 3;
    localparam int unsigned SECOND_MAG_LSB = 0;

    // Timing.
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned OFFSET_STEP_NS = 5;
    localparam int unsigned OFFSET_STEP_CYC =
        (OFFSET_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Sense samples per threshold code step.
    localparam int unsigned THRESH_STEP_LSB = 32;

endpackage

//--- design/adta_edge_offset.sv
/*
 * One edge adjuster: registers nominal time plus a signed offset when
 * enabled, otherwise the nominal time, saturating at both ends.
 * Assumes nominal times and enable come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module adta_edge_offset
    import adta_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [EDGE_W-1:0] nominal_i,
    input  wire logic              enable_i,
    input  wire logic              negative_i,
    input  wire logic [CODE_W-1:0] magnitude_i,
    output logic      [EDGE_W-1:0] adjusted_o
);

    localparam logic [EDGE_W:0] EDGE_MAX = {1'b0, {EDGE_W{1'b1}}};

    logic [EDGE_W:0]   shift_cyc;
    logic [EDGE_W:0]   sum;
    logic [EDGE_W-1:0] adjusted_d;

    always_comb begin
        shift_cyc = (EDGE_W+1)'(magnitude_i) * (EDGE_W+1)'(OFFSET_STEP_CYC); // (RULE5) (RULE6)
        sum       = {1'b0, nominal_i} + shift_cyc;
        if (!enable_i) begin
            adjusted_d = nominal_i; // (RULE2)
        end else if (negative_i) begin
            // Clamp at zero so an early edge never wraps to a late one.
            if ({1'b0, nominal_i} < shift_cyc) begin
                adjusted_d = '0;
            end else begin
                adjusted_d = nominal_i - shift_cyc[EDGE_W-1:0]; // (RULE4) (RULE7)
            end
        end else if (sum > EDGE_MAX) begin
            adjusted_d = EDGE_MAX[EDGE_W-1:0];
        end else begin
            adjusted_d = sum[EDGE_W-1:0]; // (RULE7)
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            adjusted_o <= '0;
        end else begin
            adjusted_o <= adjusted_d;
        end
    end

endmodule

`default_nettype wire

//--- design/adta_dead_time_adjust.sv
/*
 * Adaptive dead time adjust: two 8-bit registers, light-load detection on
 * the secondary current-sense sample, and signed offsets on two PWM edges.
 * Assumes the PWM engine and sense front end run on ref_clk_i, and that
 * the sense sample LSB scales with the selected nominal sense range.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// (RULE1) Threshold code sits in bits 2:0; bits 7:3 are plain read/write storage.
// (RULE2) Offsets apply only while sensed secondary current is below threshold.
// (RULE3) Threshold step follows the sense range scale; code zero means zero.
// (RULE4) Bit 7 and bit 3 give edge offset polarity; one means negative.
// (RULE5) Bits 6:4 give first edge magnitude, 5 ns per step, up to 35 ns.
// (RULE6) Bits 2:0 give second edge magnitude, 5 ns per step, up to 35 ns.
// (RULE7) Adjusted edge time is nominal plus the signed offset.
module adta_dead_time_adjust
    import adta_pkg::*;
(
    input  wire logic               ref_clk_i,
    input  wire logic               rst_n_i,
    input  wire logic [ADDR_W-1:0]  reg_addr_i,
    input  wire logic [DATA_W-1:0]  reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic      [DATA_W-1:0]  reg_rdata_o,
    input  wire logic [SENSE_W-1:0] secondary_current_sense_i,
    input  wire logic [EDGE_W-1:0]  first_nominal_i,
    input  wire logic [EDGE_W-1:0]  second_nominal_i,
    output logic      [EDGE_W-1:0]  first_pwm_edge_o,
    output logic      [EDGE_W-1:0]  second_pwm_edge_o,
    output logic                    light_load_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [DATA_W-1:0] thresh_q;
    logic [DATA_W-1:0] edges12_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thresh_q <= THRESH_RESET;
        end else if (reg_wr_i && reg_addr_i == THRESH_OFFSET) begin
            thresh_q <= reg_wdata_i; // (RULE1)
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            edges12_q <= EDGES12_RESET;
        end else if (reg_wr_i && reg_addr_i == EDGES12_OFFSET) begin
            edges12_q <= reg_wdata_i;
        end
    end

    logic [DATA_W-1:0] rdata_d;

    always_comb begin
        unique case (reg_addr_i)
            THRESH_OFFSET:  rdata_d = thresh_q; // (RULE1)
            EDGES12_OFFSET: rdata_d = edges12_q;
            default:        rdata_d = 8'h00;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe, zero otherwise.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_d;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Light-load detection.

    // The sample LSB already scales with the sense range, so comparing in
    // sample units keeps the millivolt step proportional to that range.
    logic [SENSE_W-1:0] threshold_lvl;
    logic               light_load_d;

    always_comb begin
        threshold_lvl = SENSE_W'(thresh_q[THRESH_LSB +: CODE_W])
                      * SENSE_W'(THRESH_STEP_LSB); // (RULE3)
        light_load_d  = secondary_current_sense_i < threshold_lvl; // (RULE2)
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            light_load_o <= 1'b0;
        end else begin
            light_load_o <= light_load_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge adjusters.

    adta_edge_offset u_first (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .nominal_i   (first_nominal_i),
        .enable_i    (light_load_d), // (RULE2)
        .negative_i  (edges12_q[FIRST_POL_BIT]), // (RULE4)
        .magnitude_i (edges12_q[FIRST_MAG_LSB +: CODE_W]), // (RULE5)
        .adjusted_o  (first_pwm_edge_o)
    );

    adta_edge_offset u_second (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .nominal_i   (second_nominal_i),
        .enable_i    (light_load_d), // (RULE2)
        .negative_i  (edges12_q[SECOND_POL_BIT]), // (RULE4)
        .magnitude_i (edges12_q[SECOND_MAG_LSB +: CODE_W]), // (RULE6)
        .adjusted_o  (second_pwm_edge_o)
    );

endmodule

`default_nettype wire

//--- verification/adta_checker_assertions.sv
/* Port checker for the dead time adjust block.
   Assumes it is bound to the top module and strobes never overlap. */
`timescale 1ns/1ps
`default_nettype none
module adta_checker import adta_pkg::*; (
    input wire logic ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, light_load_o,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o,
    input wire logic [SENSE_W-1:0] secondary_current_sense_i,
    input wire logic [EDGE_W-1:0] first_nominal_i, second_nominal_i,
    input wire logic [EDGE_W-1:0] first_pwm_edge_o, second_pwm_edge_o
);
    logic [7:0] thr_q, off_q;
    // Shadow copies keep the checker free of the design's internals.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) {thr_q, off_q} <= 16'h0000;
        else if (reg_wr_i && reg_addr_i == THRESH_OFFSET) thr_q <= reg_wdata_i;
        else if (reg_wr_i && reg_addr_i == EDGES12_OFFSET) off_q <= reg_wdata_i;
    end
    function automatic logic [15:0] adj(logic [15:0] n, logic [7:0] e, logic hi, logic on);
        logic [3:0] f;
        f = hi ? e[7:4] : e[3:0];
        if (!on) return n;
        if (f[3]) return (n < f[2:0]) ? 16'h0000 : n - f[2:0];
        return (n > 16'hFFFF - f[2:0]) ? 16'hFFFF : n + f[2:0];
    endfunction
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("rdata idle");
    rd_thresh_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == THRESH_OFFSET
        |-> reg_rdata_o == $past(thr_q)) else $error("thresh read");
    rd_offset_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == EDGES12_OFFSET
        |-> reg_rdata_o == $past(off_q)) else $error("offset read");
    rd_unmap_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) > 8'h69
        |-> reg_rdata_o == 8'h00) else $error("unmapped read");
    light_cmp_a: assert property ($past(rst_n_i) |-> light_load_o ==
        (($past(secondary_current_sense_i) >> 5) < $past(thr_q) % 8)) else $error("light");
    zero_code_a: assert property (thr_q % 8 == 0 |=> !light_load_o)
        else $error("code zero");
    first_adj_a: assert property ($past(rst_n_i) |-> first_pwm_edge_o ==
        adj($past(first_nominal_i), $past(off_q), 1'b1, light_load_o)) else $error("first");
    second_adj_a: assert property ($past(rst_n_i) |-> second_pwm_edge_o ==
        adj($past(second_nominal_i), $past(off_q), 1'b0, light_load_o)) else $error("second");
    cover property (light_load_o && $past(off_q) == 8'hF0);
    cover property ($fell(light_load_o));
    cover property (light_load_o && second_pwm_edge_o == 16'hFFFF);
    cover property ($past(reg_rd_i) && reg_rdata_o != 8'h00);
endmodule
bind adta_dead_time_adjust adta_checker u_adta_checker (.*);
`default_nettype wire

//--- verification/adta_switch_model.sv
/* Driver-side model: the switch drivers see only the spacing of the edges.
   Assumes edges are held between updates. */
`timescale 1ns/1ps
`default_nettype none
module adta_switch_model import adta_pkg::*; (
    input wire logic              ref_clk_i,
    input wire logic [EDGE_W-1:0] first_edge_i,
    input wire logic [EDGE_W-1:0] second_edge_i,
    output logic     [EDGE_W-1:0] gap_o
);
    // A wrapped gap would mean the two switches overlap.
    always_ff @(posedge ref_clk_i) gap_o <= second_edge_i - first_edge_i;
endmodule
`default_nettype wire

//--- verification/tb.sv
/* Bench for the dead time adjust block and the driver model.
   Assumes a 200 MHz clock and a bus that never waits. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adta_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ll;
    logic [7:0]  ad = 8'h00, wd = 8'h00, rdat;
    logic [11:0] sn = 12'h000;
    logic [15:0] n1 = 16'h0064, n2 = 16'h0064, e1, e2, gap;
    int          failures = 0, total_checks = 0;
    adta_dead_time_adjust u_adta_dead_time_adjust (.ref_clk_i(clk), .rst_n_i(rst_n),
        .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .secondary_current_sense_i(sn), .first_nominal_i(n1), .second_nominal_i(n2),
        .first_pwm_edge_o(e1), .second_pwm_edge_o(e2), .light_load_o(ll));
    adta_switch_model u_adta_switch_model (.ref_clk_i(clk), .first_edge_i(e1),
        .second_edge_i(e2), .gap_o(gap));
    initial forever #2.5 clk = ~clk;
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {wr, rd, ad, wd} <= {w, !w, a, d};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        #1 if (!w) cmp(16'(rdat), 16'(d));
    endtask
    task automatic apply(input logic [11:0] s, input logic [15:0] x1, x2, input logic l);
        @(posedge clk);
        sn <= s;
        repeat (2) @(posedge clk);
        #1 cmp(16'(ll), 16'(l));
        cmp(e1, x1);
        cmp(e2, x2);
        cmp(gap, x2 - x1);
    endtask
    task automatic t_regs;
        bus(1'b0, EDGES12_OFFSET, 8'h00);
        bus(1'b1, THRESH_OFFSET, 8'hFA);
        bus(1'b0, THRESH_OFFSET, 8'hFA);
        bus(1'b1, 8'h6A, 8'h55);
        bus(1'b0, 8'h6A, 8'h00);
    endtask
    task automatic t_thresh;
        bus(1'b1, EDGES12_OFFSET, 8'h11);
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, THRESH_OFFSET, 8'hF8 | 8'(c));
            apply(12'(c * 32 - 1), c ? 16'h0065 : 16'h0064, c ? 16'h0065 : 16'h0064, c > 0);
            apply(12'(c * 32), 16'h0064, 16'h0064, 1'b0);
        end
    endtask
    task automatic t_offsets;
        for (int k = 0; k < 16; k++) begin
            bus(1'b1, EDGES12_OFFSET, 8'(k * 16 + 15 - k));
            apply(12'h00A, k > 7 ? 16'(100 - k % 8) : 16'(100 + k % 8),
                k > 7 ? 16'(107 - k % 8) : 16'(93 + k % 8), 1'b1);
        end
    endtask
    task automatic t_clamp;
        bus(1'b1, EDGES12_OFFSET, 8'hF7);
        @(posedge clk);
        {n1, n2} <= {16'h0003, 16'hFFFD};
        apply(12'h000, 16'h0000, 16'hFFFF, 1'b1);
        apply(12'h0E0, 16'h0003, 16'hFFFD, 1'b0);
    endtask
    task automatic t_reset;
        bus(1'b1, EDGES12_OFFSET, 8'hA3);
        bus(1'b0, EDGES12_OFFSET, 8'hA3);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // A mid-run reset must bring both registers and the flag back to zero.
        bus(1'b0, THRESH_OFFSET, 8'h00);
        bus(1'b0, EDGES12_OFFSET, 8'h00);
        apply(12'h000, 16'h0003, 16'hFFFD, 1'b0);
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_thresh();
        t_offsets();
        t_clamp();
        t_reset();
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
